/* File: src/counter_gating_pkg.sv */
// Operation
// RQ1: frequency mode gates channel A edges into the chain for a range-selected window
// RQ2: period mode feeds A edges to time-base, gating reference pulses into chain
// RQ3: period range sets the number of input cycles forming the gate
// RQ4: time interval modes count reference-derived clock units selected by range
// RQ5: single-line interval starts and stops on channel B edges or manual buttons
// RQ6: separate rising/falling choices for the start edge and the stop edge
// RQ7: two-line interval starts on channel B edge, stops on channel A edge, or manual
// RQ8: ratio mode counts A while B drives time-base, gate spans range B cycles
// RQ9: ratio reading equals true A over B ratio times range factor n
// RQ10: totalize passes channel A edges through a divide-by-n prescaler to the chain
// RQ11: totalize enabled and disabled by manual buttons or channel B timing edges
// RQ12: totalize thousands range makes each count unit stand for 1000 events
// RQ13: with hold active a new measurement starts only on the reset control
// RQ14: chain counts past full scale, dropping top digits, lower digits stay valid
// RQ15: high-input-range variant offers a high-frequency setting for above 20 MHz
// RQ16: high-frequency setting divides channel A and reference by four
// RQ17: gate end stops count and displays total, then repeats unless single shot
// RQ18: result is six decimal digits, one per display position
// RQ19: all decades cleared to zero at each new cycle before gate opens
// RQ20: start/stop edges and channel inputs synchronised to the clock before use
package counter_gating_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int CLK_HZ = 50_000_000;
  localparam int REF_TICK_HZ = 1_000_000;
  localparam int REF_DIV = CLK_HZ / REF_TICK_HZ;
  localparam int REF_CNT_W = $clog2(REF_DIV);
  localparam int DISPLAY_MS = 250;
  localparam int MS_PER_S = 1000;
  localparam int DISPLAY_CYCLES_DEF = DISPLAY_MS * (CLK_HZ / MS_PER_S);
  localparam int HF_DIVIDE = 4;
  localparam logic [1:0] DIV4_LAST = 2'(HF_DIVIDE - 1);
  localparam int TOTAL_THOUSANDS = 1000;
  localparam logic [2:0] RANGE_THOUSANDS = 3'h3;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int DIGITS = 6;
  localparam int BCD_W = 4;
  localparam logic [3:0] BCD_ZERO = 4'h0;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [2:0] RANGE_MAX = 3'h6;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [2:0] FN_FREQ = 3'h0;
  localparam logic [2:0] FN_PERIOD = 3'h1;
  localparam logic [2:0] FN_TI_B = 3'h2;
  localparam logic [2:0] FN_TI_BA = 3'h3;
  localparam logic [2:0] FN_RATIO = 3'h4;
  localparam logic [2:0] FN_TOTAL = 3'h5;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_LIVE = 8'h10;

  localparam int CTRL_W = 10;
  localparam logic [9:0] CTRL_RST = 10'h0C0;
  localparam int CTRL_FUNC_LSB = 0;
  localparam int CTRL_RANGE_LSB = 3;
  localparam int CTRL_START_RISE_BIT = 6;
  localparam int CTRL_STOP_RISE_BIT = 7;
  localparam int CTRL_HF_BIT = 8;
  localparam int CTRL_HOLD_BIT = 9;

  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_RESET_BIT = 2;

  localparam int STAT_GATE_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_HELD_BIT = 2;
  localparam int STAT_OVF_BIT = 3;

  typedef enum logic [2:0] {
    ST_CLEAR,
    ST_ARM,
    ST_GATE,
    ST_LATCH,
    ST_DISPLAY,
    ST_HOLD
  } meas_state_e;

endpackage

/* File: src/decade_digit.sv */
`timescale 1ns/1ps
module decade_digit
  import counter_gating_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic clear_in,
  input wire logic inc_in,
  // digit and carry
  output logic [3:0] digit_out,
  output logic carry_out
);

  typedef struct packed {
    logic [3:0] digit;
  } digit_s;

  digit_s s_q;
  digit_s s_d;

  assign digit_out = s_q.digit;
  assign carry_out = inc_in && (s_q.digit == BCD_NINE);

  always_comb begin
    s_d = s_q;
    if (clear_in) begin
      s_d.digit = BCD_ZERO;
    end else if (inc_in) begin
      s_d.digit = (s_q.digit == BCD_NINE) ? BCD_ZERO : 4'(s_q.digit + 4'h1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

/* File: src/input_sync.sv */
`timescale 1ns/1ps
module input_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // raw level
  input wire logic sig_in,
  // edge pulses
  output logic rise_out,
  output logic fall_out
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  // first stage feeds only the second stage
  assign rise_out = s_q.sync && !s_q.prev;
  assign fall_out = !s_q.sync && s_q.prev;

  always_comb begin
    s_d.meta = sig_in;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

/* File: src/counter_gating.sv */
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module counter_gating
  import counter_gating_pkg::*;
#(
  parameter int DISPLAY_CYCLES = DISPLAY_CYCLES_DEF,
  parameter bit HF_AVAIL = 1'b1
) (
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // shaped channels
  input wire logic CHAN_A_IN,
  input wire logic CHAN_B_IN,
  // display and status
  output logic [DIGITS*BCD_W-1:0] DIGITS_OUT,
  output logic GATE_OUT,
  output logic OVERFLOW_OUT
);

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    meas_state_e st;
    logic [CTRL_W-1:0] ctrl;
    logic [DIGITS*BCD_W-1:0] result;
    logic valid;
    logic ovf;
    logic [31:0] disp_cnt;
    logic [REF_CNT_W-1:0] ref_cnt;
    logic ref_tick;
    logic [1:0] hfa_cnt;
    logic [1:0] hfr_cnt;
    logic [31:0] prdata;
    logic pslverr;
  } gate_s;

  gate_s s_q;
  gate_s s_d;

  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic [DIGITS:0] tb_carry;
  logic [DIGITS:0] cnt_carry;
  logic [DIGITS*BCD_W-1:0] tb_digits;
  logic [DIGITS*BCD_W-1:0] live_digits;
  logic chain_clr;
  logic tb_inc;
  logic cnt_inc;
  logic tb_out;
  logic [2:0] func;
  logic [2:0] range_sel;
  logic start_rise;
  logic stop_rise;
  logic hf_on;
  logic hold;
  logic a_evt;
  logic ref_evt;
  logic start_evt;
  logic stop_evt;
  logic wr_acc;
  logic cmd_start;
  logic cmd_stop;
  logic cmd_reset;
  logic setup;
  logic [31:0] status_word;

  ////////////////////////////////////////////////////////////////////////////////
  // channel conditioning
  input_sync sync_a (  // [RQ20]
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .sig_in(CHAN_A_IN),
    .rise_out(a_rise),
    .fall_out(a_fall)
  );

  input_sync sync_b (  // [RQ20]
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .sig_in(CHAN_B_IN),
    .rise_out(b_rise),
    .fall_out(b_fall)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // time-base decades and counting chain
  assign tb_carry[0] = tb_inc;
  assign cnt_carry[0] = cnt_inc;

  genvar gi;
  generate
    for (gi = 0; gi < DIGITS; gi++) begin : g_dec
      decade_digit tb_dig (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RST_N_IN),
        .clear_in(chain_clr),
        .inc_in(tb_carry[gi]),
        .digit_out(tb_digits[gi*BCD_W +: BCD_W]),
        .carry_out(tb_carry[gi+1])
      );
      // top carry dropped so the chain wraps [RQ14]
      decade_digit cnt_dig (  // [RQ18]
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RST_N_IN),
        .clear_in(chain_clr),
        .inc_in(cnt_carry[gi]),
        .digit_out(live_digits[gi*BCD_W +: BCD_W]),
        .carry_out(cnt_carry[gi+1])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // control decode
  assign func = s_q.ctrl[CTRL_FUNC_LSB +: 3];
  assign range_sel = (s_q.ctrl[CTRL_RANGE_LSB +: 3] > RANGE_MAX) ? RANGE_MAX :
                     s_q.ctrl[CTRL_RANGE_LSB +: 3];
  assign start_rise = s_q.ctrl[CTRL_START_RISE_BIT];
  assign stop_rise = s_q.ctrl[CTRL_STOP_RISE_BIT];
  assign hf_on = HF_AVAIL && s_q.ctrl[CTRL_HF_BIT] && (func == FN_FREQ);  // [RQ15]
  assign hold = s_q.ctrl[CTRL_HOLD_BIT];

  // divide-by-n decade tap of the time-base
  assign tb_out = tb_carry[range_sel];  // [RQ3]

  assign a_evt = hf_on ? (a_rise && (s_q.hfa_cnt == DIV4_LAST)) : a_rise;  // [RQ16]
  assign ref_evt = hf_on ? (s_q.ref_tick && (s_q.hfr_cnt == DIV4_LAST)) :
                   s_q.ref_tick;  // [RQ16]

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign setup = PSEL_IN && !PENABLE_IN;
  assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign cmd_start = wr_acc && (PADDR_IN == OFS_CMD) && PWDATA_IN[CMD_START_BIT];
  assign cmd_stop = wr_acc && (PADDR_IN == OFS_CMD) && PWDATA_IN[CMD_STOP_BIT];
  assign cmd_reset = wr_acc && (PADDR_IN == OFS_CMD) && PWDATA_IN[CMD_RESET_BIT];

  always_comb begin
    status_word = '0;
    status_word[STAT_GATE_BIT] = (s_q.st == ST_GATE);
    status_word[STAT_VALID_BIT] = s_q.valid;
    status_word[STAT_HELD_BIT] = (s_q.st == ST_HOLD);
    status_word[STAT_OVF_BIT] = s_q.ovf;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // start and stop sources per function
  always_comb begin
    start_evt = 1'b0;
    stop_evt = 1'b0;
    case (func)
      FN_TI_B: begin
        start_evt = cmd_start || (start_rise ? b_rise : b_fall);  // [RQ5] [RQ6]
        stop_evt = cmd_stop || (stop_rise ? b_rise : b_fall);  // [RQ5] [RQ6]
      end
      FN_TI_BA: begin
        start_evt = cmd_start || (start_rise ? b_rise : b_fall);  // [RQ7] [RQ6]
        stop_evt = cmd_stop || (stop_rise ? a_rise : a_fall);  // [RQ7] [RQ6]
      end
      FN_TOTAL: begin
        start_evt = cmd_start || (start_rise ? b_rise : b_fall);  // [RQ11]
        stop_evt = cmd_stop || (stop_rise ? b_rise : b_fall);  // [RQ11]
      end
      default: begin
        start_evt = 1'b0;
        stop_evt = 1'b0;
      end
    endcase
  end

  // steering of time-base and chain inputs
  always_comb begin
    tb_inc = 1'b0;
    cnt_inc = 1'b0;
    if (s_q.st == ST_GATE) begin
      case (func)
        FN_FREQ: begin
          tb_inc = ref_evt;  // [RQ1] [RQ16]
          cnt_inc = a_evt;  // [RQ1]
        end
        FN_PERIOD: begin
          tb_inc = a_rise;  // [RQ2] [RQ3]
          cnt_inc = s_q.ref_tick;  // [RQ2]
        end
        FN_TI_B, FN_TI_BA: begin
          tb_inc = s_q.ref_tick;  // [RQ4]
          cnt_inc = tb_out;  // [RQ4]
        end
        FN_RATIO: begin
          tb_inc = b_rise;  // [RQ8]
          cnt_inc = a_rise;  // [RQ8] [RQ9]
        end
        FN_TOTAL: begin
          tb_inc = a_rise;  // [RQ10]
          // range 3 gives one unit per TOTAL_THOUSANDS events [RQ12]
          cnt_inc = tb_out;  // [RQ10] [RQ12]
        end
        default: begin
          tb_inc = 1'b0;
          cnt_inc = 1'b0;
        end
      endcase
    end
  end

  assign chain_clr = (s_q.st == ST_CLEAR);  // [RQ19]

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer, registers and reference divider
  always_comb begin
    s_d = s_q;
    // reference tick from the clock
    s_d.ref_tick = 1'b0;
    if (s_q.ref_cnt == REF_CNT_W'(REF_DIV - 1)) begin
      s_d.ref_cnt = '0;
      s_d.ref_tick = 1'b1;
    end else begin
      s_d.ref_cnt = REF_CNT_W'(s_q.ref_cnt + 1'b1);
    end
    if (s_q.st == ST_CLEAR) begin
      s_d.hfa_cnt = '0;
      s_d.hfr_cnt = '0;
    end else if (s_q.st == ST_GATE && hf_on) begin
      if (a_rise) begin
        s_d.hfa_cnt = 2'(s_q.hfa_cnt + 2'h1);  // [RQ16]
      end
      if (s_q.ref_tick) begin
        s_d.hfr_cnt = 2'(s_q.hfr_cnt + 2'h1);  // [RQ16]
      end
    end
    if (cnt_carry[DIGITS]) begin
      s_d.ovf = 1'b1;  // [RQ14]
    end

    case (s_q.st)
      ST_CLEAR: begin
        s_d.ovf = 1'b0;
        s_d.st = ST_ARM;  // [RQ19]
      end
      ST_ARM: begin
        case (func)
          FN_FREQ: s_d.st = ST_GATE;  // [RQ1]
          FN_PERIOD: s_d.st = a_rise ? ST_GATE : ST_ARM;  // [RQ2]
          FN_RATIO: s_d.st = b_rise ? ST_GATE : ST_ARM;  // [RQ8]
          FN_TI_B, FN_TI_BA, FN_TOTAL: s_d.st = start_evt ? ST_GATE : ST_ARM;
          default: s_d.st = ST_ARM;
        endcase
      end
      ST_GATE: begin
        case (func)
          FN_FREQ, FN_PERIOD, FN_RATIO: s_d.st = tb_out ? ST_LATCH : ST_GATE;  // [RQ1]
          FN_TI_B, FN_TI_BA, FN_TOTAL: s_d.st = stop_evt ? ST_LATCH : ST_GATE;
          default: s_d.st = ST_LATCH;
        endcase
      end
      ST_LATCH: begin
        s_d.result = live_digits;  // [RQ17]
        s_d.valid = 1'b1;
        s_d.disp_cnt = '0;
        s_d.st = ST_DISPLAY;
      end
      ST_DISPLAY: begin
        if (s_q.disp_cnt == 32'(DISPLAY_CYCLES - 1)) begin
          s_d.st = hold ? ST_HOLD : ST_CLEAR;  // [RQ17] [RQ13]
        end else begin
          s_d.disp_cnt = 32'(s_q.disp_cnt + 32'h1);
        end
      end
      ST_HOLD: s_d.st = ST_HOLD;  // [RQ13]
      default: s_d.st = ST_CLEAR;
    endcase
    if (cmd_reset) begin
      s_d.st = ST_CLEAR;  // [RQ13]
    end

    // apb register file
    if (wr_acc && (PADDR_IN == OFS_CTRL)) begin
      s_d.ctrl = PWDATA_IN[CTRL_W-1:0];
    end
    if (setup) begin
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
      case (PADDR_IN)
        OFS_CTRL: s_d.prdata = 32'(s_q.ctrl);
        OFS_CMD: s_d.prdata = '0;
        OFS_STATUS: s_d.prdata = status_word;
        OFS_RESULT: s_d.prdata = 32'(s_q.result);
        OFS_LIVE: s_d.prdata = 32'(live_digits);
        default: s_d.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s_q <= '0;
      s_q.st <= ST_CLEAR;
      s_q.ctrl <= CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign PRDATA_OUT = s_q.prdata;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = s_q.pslverr && PSEL_IN && PENABLE_IN;
  assign DIGITS_OUT = s_q.result;
  assign GATE_OUT = (s_q.st == ST_GATE);
  assign OVERFLOW_OUT = s_q.ovf;

endmodule

/* File: verification/counter_gating_assertions.sv */
`timescale 1ns/1ps
module counter_gating_checker
  import counter_gating_pkg::*;
#(
  parameter int DISPLAY_CYCLES = DISPLAY_CYCLES_DEF,
  parameter bit HF_AVAIL = 1'b1
) (
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  // apb
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  // channels and display
  input wire logic CHAN_A_IN,
  input wire logic CHAN_B_IN,
  input wire logic [DIGITS*BCD_W-1:0] DIGITS_OUT,
  input wire logic GATE_OUT,
  input wire logic OVERFLOW_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic rd_acc;
  logic bcd_ok;
  assign rd_acc = PSEL_IN && PENABLE_IN && !PWRITE_IN;
  always_comb begin
    bcd_ok = 1'b1;
    for (int i = 0; i < DIGITS; i++) begin
      if (DIGITS_OUT[i*BCD_W+:BCD_W] > BCD_NINE) begin
        bcd_ok = 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_bcd_digits;
    bcd_ok;
  endproperty
  a_bcd_digits: assert property (p_bcd_digits)
    else $error("display digit out of decimal range");
  property p_digits_hold;
    GATE_OUT && $past(GATE_OUT) |-> $stable(DIGITS_OUT);
  endproperty
  a_digits_hold: assert property (p_digits_hold)
    else $error("display changed while gate open");
  property p_gate_rest;
    $fell(GATE_OUT) |-> !GATE_OUT [*2];
  endproperty
  a_gate_rest: assert property (p_gate_rest)
    else $error("gate reopened too soon");
  property p_ovf_in_gate;
    $rose(OVERFLOW_OUT) |-> $past(GATE_OUT);
  endproperty
  a_ovf_in_gate: assert property (p_ovf_in_gate)
    else $error("overflow set outside gate");
  property p_result_read;
    rd_acc && PADDR_IN == OFS_RESULT |-> PRDATA_OUT[23:0] == $past(DIGITS_OUT);
  endproperty
  a_result_read: assert property (p_result_read)
    else $error("result read differs from display");
  property p_status_read;
    rd_acc && PADDR_IN == OFS_STATUS |-> PRDATA_OUT[STAT_GATE_BIT] == $past(GATE_OUT)
      && PRDATA_OUT[STAT_OVF_BIT] == $past(OVERFLOW_OUT);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status gate or overflow bit wrong");
  property p_latch_time;
    $changed(DIGITS_OUT) |-> $past(GATE_OUT, 2) && !$past(GATE_OUT);
  endproperty
  a_latch_time: assert property (p_latch_time)
    else $error("display updated outside latch step");
  property p_held_quiet;
    rd_acc && PADDR_IN == OFS_STATUS && PRDATA_OUT[STAT_HELD_BIT] |-> !$past(GATE_OUT);
  endproperty
  a_held_quiet: assert property (p_held_quiet)
    else $error("held status with gate open");
endmodule

bind counter_gating counter_gating_checker #(
  .DISPLAY_CYCLES(DISPLAY_CYCLES), .HF_AVAIL(HF_AVAIL)
) u_counter_gating_checker (.*);

/* File: verification/chan_source.sv */
`timescale 1ns/1ps
module chan_source (
  // clock and control
  input wire logic clk_in,
  input wire logic en_in,
  input wire logic [15:0] a_half_in,
  input wire logic [15:0] b_half_in,
  input wire logic [15:0] a_skew_in,
  // shaped levels, low while stopped
  output logic a_out,
  output logic b_out
);
  logic [15:0] ca;
  logic [15:0] cb;
  always_ff @(posedge clk_in) begin
    if (!en_in) begin
      ca <= a_skew_in;
      cb <= '0;
      a_out <= 1'b0;
      b_out <= 1'b0;
    end else begin
      ca <= (ca == a_half_in - 16'h1) ? '0 : ca + 16'h1;
      cb <= (cb == b_half_in - 16'h1) ? '0 : cb + 16'h1;
      if (ca == a_half_in - 16'h1) begin
        a_out <= !a_out;
      end
      if (cb == b_half_in - 16'h1) begin
        b_out <= !b_out;
      end
    end
  end
endmodule

/* File: verification/test_counter_gating.sv */
`timescale 1ns/1ps
module test_counter_gating;
  import counter_gating_pkg::*;
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
  typedef struct {logic [9:0] ctrl; int ah; int bh; int sk; int ex;} row_s;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, chan_a, chan_b, gate, ovf, en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] digits;
  logic [15:0] ah, bh, sk;
  logic er;
  int mismatches, n_compared, v, k;
  row_s rows[11] = '{'{10'h0C1, 250, 100, 0, 10}, '{10'h0C9, 250, 100, 0, 100},
    '{10'h0C4, 10, 100, 5, 10}, '{10'h0CC, 10, 100, 5, 100}, '{10'h042, 100, 500, 0, 10},
    '{10'h082, 100, 500, 0, 10},
    '{10'h04A, 100, 2500, 0, 5}, '{10'h043, 500, 500, 0, 10}, '{10'h0C5, 10, 1000, 5, 100},
    '{10'h0CD, 10, 1000, 5, 10}, '{10'h0DD, 5, 5000, 3, 1}};
  counter_gating #(.DISPLAY_CYCLES(8)) u_counter_gating (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .CHAN_A_IN(chan_a), .CHAN_B_IN(chan_b), .DIGITS_OUT(digits), .GATE_OUT(gate),
    .OVERFLOW_OUT(ovf));
  chan_source u_chan_source (.clk_in(clk), .en_in(en), .a_half_in(ah), .b_half_in(bh),
    .a_skew_in(sk), .a_out(chan_a), .b_out(chan_b));
  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      stop_test();
    end
  endtask
  task automatic wait_gate(input logic val);
    int n;
    n = 0;
    while (gate !== val && n < 30000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 30000) begin
      mismatches++;
      $display("ERROR gate expected %0h seen %0h", val, gate);
      stop_test();
    end
  endtask
  function automatic int dec(input logic [23:0] d);
    int r;
    r = 0;
    for (int i = 5; i >= 0; i--) r = r * 10 + int'(d[i*4+:4]);
    return r;
  endfunction
  task automatic measure();
    // let a pending restart settle before looking at the gate
    @(negedge clk);
    wait_gate(1'b1);
    wait_gate(1'b0);
    repeat (4) @(negedge clk);
    v = dec(digits);
  endtask
  task automatic start(input logic [9:0] c, input int a, input int b, input int s);
    @(posedge clk);
    en <= 1'b0;
    ah <= 16'(a);
    bh <= 16'(b);
    sk <= 16'(s);
    @(posedge clk);
    en <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'(c));
    apb(1'b1, OFS_CMD, 32'h4);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, en, sk} = '0;
    {ah, bh} = {16'h0064, 16'h0064};
    mismatches = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl reset", 32'(CTRL_RST), rd)
    apb(1'b1, 8'h20, 32'h3FF);
    `CHK("unmapped err", 1'b1, er)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl kept", 32'(CTRL_RST), rd)
    apb(1'b0, OFS_CMD, 32'h0);
    `CHK("cmd read", 32'h0, rd)
    foreach (rows[r]) begin
      start(rows[r].ctrl, rows[r].ah, rows[r].bh, rows[r].sk);
      measure();
      `CHK("row result", rows[r].ex, v)
      apb(1'b0, OFS_RESULT, 32'h0);
      `CHK("result reg", rows[r].ex, dec(rd[23:0]))
      `CHK("no overflow", 1'b0, ovf)
    end
    start(10'h0C8, 5, 100, 0);
    measure();
    `CHK("freq", 1'b1, v inside {[44:50]})
    measure();
    `CHK("freq again", 1'b1, v inside {[44:50]})
    start(10'h1C8, 5, 100, 0);
    measure();
    `CHK("freq hf", 1'b1, v inside {[44:50]})
    start(10'h2C1, 250, 100, 0);
    measure();
    repeat (30) @(negedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("held", 1'b1, rd[STAT_HELD_BIT])
    apb(1'b0, OFS_LIVE, 32'h0);
    `CHK("live held", 10, dec(rd[23:0]))
    k = 0;
    repeat (1500) begin
      @(negedge clk);
      k += int'(gate);
    end
    `CHK("hold gate", 0, k)
    apb(1'b1, OFS_CMD, 32'h4);
    measure();
    `CHK("after reset", 10, v)
    start(10'h042, 100, 100, 0);
    en <= 1'b0;
    apb(1'b1, OFS_CMD, 32'h1);
    repeat (1000) @(posedge clk);
    apb(1'b1, OFS_CMD, 32'h2);
    wait_gate(1'b0);
    repeat (4) @(negedge clk);
    v = int'(digits[7:4]) * 10 + int'(digits[3:0]);
    `CHK("manual interval", 1'b1, v inside {[20:21]})
    stop_test();
  end
endmodule
